// ---- core/uqc_input_mode_control.sv ----
// Functional notes
// - Three modes; quadrature after reset
// - Mode follows the programmed mode control
// - Quadrature mode drives pin as word clock
// - Word clock twice channel rate; I/Q pairs
// - Modulator: I times cos minus Q times sin
// - Single tone: paths off, pin is strobe
// - Single tone output is synthesizer cosine
// - Strobe rising edge loads selected tuning word
// - Profile change activates its word without strobe
// - Interpolating mode: synthesizer, modulator, Q off
// - Interpolating mode: one I word per edge
// - Interpolating mode: baseband, upsampled, images smoothed
// - Port words are 14-bit two's complement
// - Interleaved words demultiplexed into I and Q
// - All timing from the one system clock
// - Word clock continuous; optionally waits for lock
// - Gate low in quadrature mode: ignore port, feed zeros
// - After gate rise: I first, then Q alternately
// - Inverse sinc and scaling usable in all modes
module uqc_input_mode_control
  import uqc_pkg::*;
(
  // Clock, reset, enable
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic core_ce_in,
  // Configuration from control logic on this clock
  input wire logic [1:0] mode_sel_in,
  input wire logic lock_qualify_in,
  input wire logic inv_sinc_en_in,
  input wire logic [SCALE_W-1:0] amp_scale_in,
  input wire uqc_ftw_bank_type ftw_bank_in,
  // Device pins
  input wire logic pll_lock_in,
  input wire logic [DATA_W-1:0] port_data_in,
  input wire logic transmit_gate_in,
  input wire logic profile_select_bit0_in,
  input wire logic profile_select_bit1_in,
  input wire logic word_clock_or_update_pin_in,
  output logic word_clock_or_update_pin_out,
  output logic word_clock_or_update_pin_oe_out,
  // Internal streams and status
  output uqc_iq_type iq_out,
  output logic iq_valid_out,
  output logic signed [DATA_W-1:0] dac_out,
  output uqc_mode_type mode_out
);

  uqc_pins_type meta_q;
  uqc_pins_type sync_q;
  uqc_mode_type mode_q;
  logic [3:0] wc_cnt_q;
  logic word_clk_q;
  logic oe_q;
  logic rise_q;
  logic rise2_q;
  logic sel_q;
  logic flush_q;
  logic signed [DATA_W-1:0] i_hold_q;
  uqc_iq_type iq_q;
  logic iq_valid_q;
  logic upd_prev_q;
  logic [1:0] prof_q;
  logic nco_load_q;
  logic [FTW_W-1:0] nco_ftw_q;
  logic signed [DATA_W-1:0] prev_i_q;
  logic signed [DATA_W-1:0] src_q;
  logic signed [DATA_W-1:0] tap1_q;
  logic signed [DATA_W-1:0] tap2_q;
  logic signed [DATA_W-1:0] dac_q;
  logic signed [DATA_W-1:0] nco_cos_w;
  logic signed [DATA_W-1:0] nco_sin_w;

  // Clamp a wide signed result into the 14-bit data range
  function automatic logic signed [DATA_W-1:0] sat14(input logic signed [31:0] v);
    if (v > 32'sd8191) begin
      return 14'h1fff;
    end else if (v < -32'sd8192) begin
      return 14'h2000;
    end
    return v[DATA_W-1:0];
  endfunction

  // Unknown codes keep the current mode rather than guessing one
  function automatic uqc_mode_type mode_decode(input logic [1:0] code, input uqc_mode_type cur);
    case (code)
      MODE_CODE_QUAD: return UQC_QUAD;
      MODE_CODE_TONE: return UQC_TONE;
      MODE_CODE_IDAC: return UQC_IDAC;
      default: return cur;
    endcase
  endfunction

  // Pin bundle and synchronised views
  wire uqc_pins_type pins_w = '{data: port_data_in, gate: transmit_gate_in, ps1: profile_select_bit1_in,
                                ps0: profile_select_bit0_in, upd: word_clock_or_update_pin_in, lock: pll_lock_in};
  wire signed [DATA_W-1:0] data_s_w = sync_q.data;
  wire gate_s_w = sync_q.gate;
  wire lock_s_w = sync_q.lock;
  wire upd_s_w = sync_q.upd;
  wire [1:0] prof_s_w = {sync_q.ps1, sync_q.ps0};

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (core_ce_in) begin
      meta_q <= pins_w;
      sync_q <= meta_q;
    end
  end

  wire uqc_mode_type mode_d = mode_decode(mode_sel_in, mode_q);

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      mode_q <= UQC_QUAD;
    end else if (core_ce_in) begin
      mode_q <= mode_d;
    end
  end

  // Word clock: the half period is fixed when a phase starts, so a mode change never chops a phase
  wire wc_toggle_w = (wc_cnt_q == 4'h0);
  wire [3:0] wc_half_w = (mode_q == UQC_IDAC) ? WCLK_HALF_IDAC : WCLK_HALF_QUAD;
  wire wc_run_w = (mode_q != UQC_TONE) && !(lock_qualify_in && !lock_s_w);
  wire wc_d = wc_toggle_w ? (!word_clk_q && wc_run_w) : word_clk_q;
  wire wc_rise_w = wc_d && !word_clk_q;

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      wc_cnt_q <= 4'h0;
      word_clk_q <= 1'b0;
    end else if (core_ce_in) begin
      wc_cnt_q <= wc_toggle_w ? wc_half_w - 4'h1 : wc_cnt_q - 4'h1;
      word_clk_q <= wc_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      oe_q <= 1'b1;
    end else if (core_ce_in) begin
      oe_q <= (mode_q != UQC_TONE);
    end
  end

  // The pin value taken at the rising edge reaches the synchroniser output two cycles later
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      rise_q <= 1'b0;
      rise2_q <= 1'b0;
    end else if (core_ce_in) begin
      rise_q <= wc_rise_w;
      rise2_q <= rise_q;
    end
  end

  // Capture decode per mode
  wire cap_w = rise2_q;
  wire quad_cap_w = cap_w && (mode_q == UQC_QUAD);
  wire idac_cap_w = cap_w && (mode_q == UQC_IDAC);
  wire flush_w = quad_cap_w && !gate_s_w;
  wire take_i_w = quad_cap_w && gate_s_w && !sel_q;
  wire take_q_w = quad_cap_w && gate_s_w && sel_q;
  wire zero_pair_w = flush_w && flush_q;
  wire tone_w = (mode_q == UQC_TONE);

  // demux, Q held at zero, paths cleared in tone
  wire uqc_iq_type iq_d = tone_w ? '0 :
                          take_q_w ? {i_hold_q, data_s_w} :
                          idac_cap_w ? {data_s_w, 14'h0000} :
                          zero_pair_w ? '0 : iq_q;
  wire iq_valid_d = take_q_w || idac_cap_w || zero_pair_w;
  wire sel_d = (mode_q != UQC_QUAD) ? 1'b0 : take_i_w ? 1'b1 : (take_q_w || flush_w) ? 1'b0 : sel_q;
  // zeros at pair rate while gate low
  wire flush_d = flush_w ? !flush_q : (gate_s_w ? 1'b0 : flush_q);

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      sel_q <= 1'b0;
      flush_q <= 1'b0;
      i_hold_q <= 14'h0000;
      iq_q <= '0;
      iq_valid_q <= 1'b0;
    end else if (core_ce_in) begin
      sel_q <= sel_d;
      flush_q <= flush_d;
      i_hold_q <= take_i_w ? data_s_w : i_hold_q;
      iq_q <= iq_d;
      iq_valid_q <= iq_valid_d;
    end
  end

  wire upd_rise_w = tone_w && upd_s_w && !upd_prev_q;
  wire prof_chg_w = (prof_s_w != prof_q);

  // Tuning word transfer into the synthesizer
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      upd_prev_q <= 1'b0;
      prof_q <= PROFILE_RESET;
      nco_load_q <= 1'b0;
      nco_ftw_q <= FTW_RESET;
    end else if (core_ce_in) begin
      upd_prev_q <= upd_s_w;
      prof_q <= prof_s_w;
      nco_load_q <= upd_rise_w || prof_chg_w;
      nco_ftw_q <= ftw_bank_in[prof_s_w];
    end
  end

  wire nco_en_w = (mode_q != UQC_IDAC);
  uqc_nco uqc_nco_inst (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .core_ce_in(core_ce_in),
    .enable_in(nco_en_w),
    .load_in(nco_load_q),
    .ftw_in(nco_ftw_q),
    .cos_out(nco_cos_w),
    .sin_out(nco_sin_w)
  );

  // quadrature mix of the held pair
  wire signed [31:0] mix_w = 32'(iq_q.i * nco_cos_w) - 32'(iq_q.q * nco_sin_w);
  wire signed [DATA_W-1:0] mod_w = sat14(mix_w >>> NCO_FRAC);
  wire signed [31:0] avg_w = (32'(iq_q.i) + 32'(prev_i_q)) >>> 1;
  wire signed [DATA_W-1:0] src_d = tone_w ? nco_cos_w : (mode_q == UQC_IDAC) ? sat14(avg_w) : mod_w;

  // Source select and previous I for smoothing
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      prev_i_q <= 14'h0000;
      src_q <= 14'h0000;
    end else if (core_ce_in) begin
      prev_i_q <= iq_valid_q ? iq_q.i : prev_i_q;
      src_q <= src_d;
    end
  end

  // inverse sinc and scaling in every mode
  wire signed [31:0] isinc_acc_w = 32'(tap1_q) * ISINC_CENTER - 32'(src_q) - 32'(tap2_q);
  wire signed [DATA_W-1:0] eq_w = inv_sinc_en_in ? sat14(isinc_acc_w >>> ISINC_SHIFT) : tap1_q;
  wire signed [31:0] scaled_w = (32'(eq_w) * $signed({1'b0, amp_scale_in})) >>> SCALE_SHIFT;

  // Taps and output register; bypass keeps the same latency so switching does not slip samples
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      tap1_q <= 14'h0000;
      tap2_q <= 14'h0000;
      dac_q <= 14'h0000;
    end else if (core_ce_in) begin
      tap1_q <= src_q;
      tap2_q <= tap1_q;
      dac_q <= sat14(scaled_w);
    end
  end

  // Outputs straight from flip-flops
  assign word_clock_or_update_pin_out = word_clk_q;
  assign word_clock_or_update_pin_oe_out = oe_q;
  assign iq_out = iq_q;
  assign iq_valid_out = iq_valid_q;
  assign dac_out = dac_q;
  assign mode_out = mode_q;

  // Checks; a dropped clock enable abandons any sequence in flight
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in || !core_ce_in);

  sequence quad_high_s;
    word_clk_q[*4] ##1 !word_clk_q;
  endsequence

  sequence idac_high_s;
    word_clk_q[*8] ##1 !word_clk_q;
  endsequence

  sequence i_then_q_s;
    take_i_w ##[1:40] take_q_w;
  endsequence

  sequence profile_move_s;
    prof_chg_w;
  endsequence

  mode_reset_a: assert property ($rose(nrst_in) |-> mode_q == UQC_QUAD)
    else $error("mode after reset is not quadrature");

  pin_dir_a: assert property (mode_q == UQC_TONE |=> !word_clock_or_update_pin_oe_out)
    else $error("pin still driven in tone mode");

  quad_wclk_a: assert property ($rose(word_clk_q) && $past(mode_q) == UQC_QUAD |-> quad_high_s)
    else $error("quadrature word clock high phase wrong");

  idac_wclk_a: assert property ($rose(word_clk_q) && $past(mode_q) == UQC_IDAC |-> idac_high_s)
    else $error("interpolating word clock high phase wrong");

  lock_gate_a: assert property (lock_qualify_in && !lock_s_w |=> !$rose(word_clk_q))
    else $error("word clock rose before lock");

  gate_zero_a: assert property (zero_pair_w |=> iq_valid_q && iq_q == '0)
    else $error("gate low did not feed zeros");

  pair_order_a: assert property (i_then_q_s |=> iq_valid_q && iq_q.i == $past(i_hold_q, 1))
    else $error("I word not paired with following Q");

  tone_load_a: assert property (mode_q == UQC_TONE && $rose(upd_s_w) |=> nco_load_q)
    else $error("strobe edge did not load tuning word");

  profile_load_a: assert property (profile_move_s |=> nco_load_q && nco_ftw_q == ftw_bank_in[$past(prof_s_w)])
    else $error("profile change did not load its word");

  idac_q_off_a: assert property (iq_valid_q && mode_q == UQC_IDAC |-> iq_q.q == '0)
    else $error("Q path active in interpolating mode");

  tone_clear_a: assert property (tone_w |=> iq_q == '0 && !iq_valid_q)
    else $error("data path not cleared in tone mode");

  idac_nco_off_a: assert property (mode_q == UQC_IDAC |=> nco_cos_w == '0 && nco_sin_w == '0)
    else $error("synthesizer running in interpolating mode");

  tone_src_a: assert property (tone_w |=> src_q == $past(nco_cos_w))
    else $error("tone source is not the synthesizer cosine");

endmodule

// ---- core/uqc_nco.sv ----
module uqc_nco
  import uqc_pkg::*;
(
  // Clock, reset, enable
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic core_ce_in,
  // Control
  input wire logic enable_in,
  input wire logic load_in,
  input wire logic [FTW_W-1:0] ftw_in,
  // Carrier
  output logic signed [DATA_W-1:0] cos_out,
  output logic signed [DATA_W-1:0] sin_out
);

  logic [FTW_W-1:0] phase_q;
  logic [FTW_W-1:0] freq_q;
  logic signed [DATA_W-1:0] cos_q;
  logic signed [DATA_W-1:0] sin_q;

  // Coarse 16-point sine; fine enough for control tests, not for spectral purity
  function automatic logic signed [DATA_W-1:0] sine16(input logic [3:0] k);
    logic [DATA_W-1:0] mag;
    mag = 14'h0000;
    case (k[2:0])
      3'h1, 3'h7: mag = 14'h0c3f;
      3'h2, 3'h6: mag = 14'h16a0;
      3'h3, 3'h5: mag = 14'h1d90;
      3'h4: mag = 14'h1fff;
      default: mag = 14'h0000;
    endcase
    return k[3] ? -$signed(mag) : $signed(mag);
  endfunction

  wire [FTW_W-1:0] cos_phase_w = phase_q + QUARTER_TURN;

  // Accumulator: a load restarts synthesis from phase zero at the new rate
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      phase_q <= FTW_RESET;
      freq_q <= FTW_RESET;
    end else if (core_ce_in) begin
      if (load_in) begin
        freq_q <= ftw_in;
        phase_q <= FTW_RESET;
      end else if (enable_in) begin
        phase_q <= phase_q + freq_q;
      end
    end
  end

  // Carrier outputs are silent while the synthesizer is disabled
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      cos_q <= 14'h0000;
      sin_q <= 14'h0000;
    end else if (core_ce_in) begin
      cos_q <= enable_in ? sine16(cos_phase_w[31:28]) : 14'h0000;
      sin_q <= enable_in ? sine16(phase_q[31:28]) : 14'h0000;
    end
  end

  assign cos_out = cos_q;
  assign sin_out = sin_q;

endmodule

// ---- core/uqc_pkg.sv ----
package uqc_pkg;

  // Data and tuning widths
  localparam int DATA_W = 14;
  localparam int FTW_W = 32;
  localparam int NUM_PROFILES = 4;
  localparam int SCALE_W = 8;

  // Mode codes presented on the mode select port
  localparam logic [1:0] MODE_CODE_QUAD = 2'h0;
  localparam logic [1:0] MODE_CODE_TONE = 2'h1;
  localparam logic [1:0] MODE_CODE_IDAC = 2'h2;

  // Word clock half periods in system clock cycles
  localparam logic [3:0] WCLK_HALF_QUAD = 4'h4;
  localparam logic [3:0] WCLK_HALF_IDAC = 4'h8;

  // Arithmetic scaling
  localparam int NCO_FRAC = 13;
  localparam int SCALE_SHIFT = 7;
  localparam int ISINC_CENTER = 18;
  localparam int ISINC_SHIFT = 4;
  localparam logic [FTW_W-1:0] QUARTER_TURN = 32'h4000_0000;

  // Reset values
  localparam logic [FTW_W-1:0] FTW_RESET = 32'h0000_0000;
  localparam logic [1:0] PROFILE_RESET = 2'h0;

  typedef enum logic [1:0] {
    UQC_QUAD,
    UQC_TONE,
    UQC_IDAC
  } uqc_mode_type;

  // One internal sample: an I word and its Q partner
  typedef struct packed {
    logic signed [DATA_W-1:0] i;
    logic signed [DATA_W-1:0] q;
  } uqc_iq_type;

  // Pins that arrive from outside the clock domain
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic gate;
    logic ps1;
    logic ps0;
    logic upd;
    logic lock;
  } uqc_pins_type;

  typedef logic [NUM_PROFILES-1:0][FTW_W-1:0] uqc_ftw_bank_type;

endpackage

// ---- tb/uqc_input_mode_control_tb_top.sv ----
module uqc_input_mode_control_tb_top
  import uqc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, lockq, isinc, lock, ps0, ps1, upd, gate_req, fix_en, ce;
  logic [1:0] msel;
  logic [SCALE_W-1:0] amp;
  uqc_ftw_bank_type bank;
  logic signed [DATA_W-1:0] fix_w;
  uqc_mode_type tmode;
  wire logic [DATA_W-1:0] pdata;
  wire logic pgate, wclk, woe, ivld, evld;
  wire uqc_iq_type iq, epair;
  wire logic signed [DATA_W-1:0] dac;
  wire uqc_mode_type mode;
  // Pin level: device drives it unless it has let go in tone mode
  wire logic pin_lvl = woe ? wclk : upd;
  int error_cnt = 0, num_checks = 0, zero_cnt = 0, pair_cnt = 0, rise_cnt = 0, per_cnt = 0, exp_per, cyc = 0;
  int z, p, r, n;
  bit chk_en, per_en, per_seen = 0, chk_dly = 0;
  logic wprev = 1'b0;
  uqc_iq_type exp_q[$];

  uqc_input_mode_control uqc_input_mode_control_inst (.core_clk_in(clk), .nrst_in(nrst), .core_ce_in(ce),
    .mode_sel_in(msel), .lock_qualify_in(lockq), .inv_sinc_en_in(isinc), .amp_scale_in(amp),
    .ftw_bank_in(bank), .pll_lock_in(lock), .port_data_in(pdata), .transmit_gate_in(pgate),
    .profile_select_bit0_in(ps0), .profile_select_bit1_in(ps1), .word_clock_or_update_pin_in(pin_lvl),
    .word_clock_or_update_pin_out(wclk), .word_clock_or_update_pin_oe_out(woe), .iq_out(iq),
    .iq_valid_out(ivld), .dac_out(dac), .mode_out(mode));

  uqc_src_model uqc_src_model_inst (.core_clk_in(clk), .mode_in(tmode), .gate_req_in(gate_req),
    .fix_en_in(fix_en), .fix_word_in(fix_w), .word_clk_in(wclk), .word_clk_oe_in(woe),
    .port_data_out(pdata), .transmit_gate_out(pgate), .exp_pair_out(epair), .exp_valid_out(evld));

  // System clock, 5 ns
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk_pair(input uqc_iq_type e, input uqc_iq_type g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_val(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cyc_n(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Counts output changes over 16 cycles
  task automatic changes(output int cnt);
    logic [DATA_W-1:0] prv;
    cnt = 0;
    @(negedge clk);
    prv = dac;
    repeat (16) begin
      @(negedge clk);
      if (dac !== prv) cnt++;
      prv = dac;
    end
  endtask

  task automatic stop_test;
    $display("errors=%0d checks=%0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Monitor: word clock period, queued pairs against what the device emits
  always @(negedge clk) begin
    per_cnt++;
    if (!per_en) per_seen = 0;
    if (wclk === 1'b1 && wprev === 1'b0) begin
      rise_cnt++;
      if (per_en && per_seen) chk_val(exp_per, per_cnt);
      per_seen = per_en;
      per_cnt = 0;
    end
    wprev = wclk;
    // Checking lags noting by the model's one-cycle lead, so a pair is noted and checked or neither
    if (chk_en && evld) exp_q.push_back(epair);
    if (chk_dly && ivld === 1'b1) begin
      if (iq === '0) zero_cnt++;
      else if (exp_q.size() == 0) begin
        error_cnt++;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, 28'h0, iq);
      end else begin
        pair_cnt++;
        chk_pair(exp_q.pop_front(), iq);
      end
    end
    chk_dly = chk_en;
  end

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    void'($urandom(32'h2f79));
    nrst = 0; lockq = 0; isinc = 0; amp = 8'h80; bank = '0; lock = 1; ps0 = 0; ps1 = 0; upd = 0; ce = 1;
    msel = 2'h0; tmode = UQC_QUAD; gate_req = 0; fix_en = 0; fix_w = 14'h0001; chk_en = 1; per_en = 0;
    exp_per = 8;
    cyc_n(6);
    nrst <= 1'b1;
    cyc_n(2);
    @(negedge clk);
    chk_val(32'(UQC_QUAD), 32'(mode));
    chk_val(1, woe);
    // Transmit in quadrature mode, then idle, then transmit again
    @(posedge clk);
    gate_req <= 1'b1;
    per_en <= 1'b1;
    cyc_n(60);
    z = zero_cnt;
    p = pair_cnt;
    cyc_n(400);
    @(negedge clk);
    chk_val(z, zero_cnt);
    chk_val(1, 32'(pair_cnt > p));
    @(posedge clk);
    gate_req <= 1'b0;
    cyc_n(200);
    @(negedge clk);
    chk_val(1, 32'(zero_cnt > z));
    @(posedge clk);
    gate_req <= 1'b1;
    cyc_n(200);
    // Word clock held back while the multiplier is unlocked
    gate_req <= 1'b0;
    per_en <= 1'b0;
    cyc_n(40);
    lockq <= 1'b1;
    lock <= 1'b0;
    cyc_n(20);
    r = rise_cnt;
    cyc_n(100);
    @(negedge clk);
    chk_val(0, rise_cnt - r);
    @(posedge clk);
    lock <= 1'b1;
    cyc_n(40);
    chk_val(1, 32'(rise_cnt > r));
    lockq <= 1'b0;
    // Interpolating mode: stale notes dropped across the switch
    chk_en <= 1'b0;
    msel <= 2'h2;
    tmode <= UQC_IDAC;
    cyc_n(3);
    @(negedge clk);
    chk_val(32'(UQC_IDAC), 32'(mode));
    @(posedge clk);
    gate_req <= 1'b1;
    cyc_n(40);
    exp_q.delete();
    chk_en <= 1'b1;
    exp_per <= 16;
    per_en <= 1'b1;
    cyc_n(300);
    fix_w <= DATA_W'($urandom) | 14'h0001;
    fix_en <= 1'b1;
    cyc_n(80);
    @(negedge clk);
    chk_val(32'(fix_w), 32'(dac));
    @(posedge clk);
    isinc <= 1'b1;
    cyc_n(20);
    @(negedge clk);
    chk_val(32'(fix_w), 32'(dac));
    @(posedge clk);
    amp <= 8'h40;
    cyc_n(20);
    @(negedge clk);
    chk_val(32'(fix_w >>> 1), 32'(dac));
    @(posedge clk);
    amp <= 8'h80;
    isinc <= 1'b0;
    fix_en <= 1'b0;
    gate_req <= 1'b0;
    chk_en <= 1'b0;
    per_en <= 1'b0;
    cyc_n(40);
    // Single tone: pin released, strobe and profile pins move the tone
    msel <= 2'h1;
    tmode <= UQC_TONE;
    cyc_n(20);
    @(negedge clk);
    chk_val(0, woe);
    chk_val(0, wclk);
    chk_val(0, 32'(iq));
    @(posedge clk);
    bank[0] <= 32'h1000_0000;
    cyc_n(30);
    changes(n);
    chk_val(0, n);
    @(posedge clk);
    upd <= 1'b1;
    cyc_n(4);
    upd <= 1'b0;
    cyc_n(20);
    changes(n);
    chk_val(1, 32'(n > 0));
    @(posedge clk);
    bank[1] <= 32'h0000_0000;
    ps0 <= 1'b1;
    cyc_n(20);
    changes(n);
    chk_val(0, n);
    @(posedge clk);
    bank[2] <= 32'h0800_0000;
    ps0 <= 1'b0;
    ps1 <= 1'b1;
    cyc_n(20);
    changes(n);
    chk_val(1, 32'(n > 0));
    // Enable low freezes the running tone
    @(posedge clk);
    ce <= 1'b0;
    cyc_n(1);
    changes(n);
    chk_val(0, n);
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    amp <= 8'h00;
    cyc_n(20);
    @(negedge clk);
    chk_val(0, 32'(dac));
    @(posedge clk);
    amp <= 8'h80;
    msel <= 2'h3;
    cyc_n(4);
    @(negedge clk);
    chk_val(32'(UQC_TONE), 32'(mode));
    @(posedge clk);
    msel <= 2'h0;
    tmode <= UQC_QUAD;
    cyc_n(20);
    @(negedge clk);
    chk_val(1, woe);
    chk_val(32'(UQC_QUAD), 32'(mode));
    // Carrier parked at phase zero by a zero-rate profile: output is I within one step, Q meets a zero sine
    @(posedge clk);
    ps0 <= 1'b1;
    ps1 <= 1'b0;
    fix_w <= 14'h1000;
    fix_en <= 1'b1;
    gate_req <= 1'b1;
    cyc_n(80);
    @(negedge clk);
    chk_val(1, 32'(dac >= 14'h0fff && dac <= 14'h1000));
    stop_test();
  end
endmodule

// ---- tb/uqc_src_model.sv ----
module uqc_src_model
  import uqc_pkg::*;
(
  // Clock and bench control
  input wire logic core_clk_in,
  input wire uqc_mode_type mode_in,
  input wire logic gate_req_in,
  input wire logic fix_en_in,
  input wire logic [DATA_W-1:0] fix_word_in,
  // Shared pin seen from the device
  input wire logic word_clk_in,
  input wire logic word_clk_oe_in,
  // Parallel port toward the device
  output logic [DATA_W-1:0] port_data_out = 14'h0001,
  output logic transmit_gate_out = 1'b0,
  // Pair the device should produce
  output uqc_iq_type exp_pair_out = '0,
  output logic exp_valid_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_prev_q = 1'b0;
  logic phase_q = 1'b0;
  logic [DATA_W-1:0] i_hold_q = '0;
  wire logic rise = word_clk_in & word_clk_oe_in & ~clk_prev_q;

  // Source follows the word clock; words are already shaped samples
  // change after rise, two's complement, gate even
  always @(posedge core_clk_in) begin
    clk_prev_q <= word_clk_in;
    exp_valid_out <= 1'b0;
    if (rise) begin
      if (mode_in == UQC_IDAC) begin
        exp_pair_out <= {port_data_out, 14'h0000};
        exp_valid_out <= 1'b1;
      end else if (transmit_gate_out && phase_q) begin
        exp_pair_out <= {i_hold_q, port_data_out};
        exp_valid_out <= 1'b1;
        phase_q <= 1'b0;
      end else if (transmit_gate_out) begin
        i_hold_q <= port_data_out;
        phase_q <= 1'b1;
      end else begin
        phase_q <= 1'b0;
      end
      // Gate only moves between pairs so no I word is left alone
      if (mode_in == UQC_IDAC || !transmit_gate_out || phase_q) begin
        transmit_gate_out <= gate_req_in;
      end
      // Bit 0 set keeps real pairs apart from the zero pairs
      port_data_out <= fix_en_in ? fix_word_in : (DATA_W'($urandom) | 14'h0001);
    end
  end
endmodule
